// ===== include/sbcfd_defines.svh
// constants of the sbc spi frame decoder
// Summary of operation
// R1 - each transaction is one 16-bit frame while chip select stays low
// R2 - mosi bits 15 and 14 select write, read back or flag read
// R3 - mosi bits 13 to 9 form the five-bit register address
// R4 - master drives bit 8 as parity in writes, as 1 in reads
// R5 - mosi bits 7 to 0 carry the data that a write stores
// R6 - device shifts the fixed status byte out on miso bits 15 to 8
// R7 - miso bits 7 to 0 carry extended status, register content or flags
// R8 - no mosi pass-through to miso; no daisy chain, one select per device
// R9 - code 00 reads back register content; master sets bit 8 to 1
// R10 - code 01 writes; bit 8 is parity 1, or 0 when unused or zero
// R11 - code 10 is reserved: no write and no flag action
// R12 - code 11 returns the flags of the addressed register; bit 8 is 1
// R13 - every register reads back its default or last written value
// R14 - write frames return fixed status then extended status
// R15 - read frames return fixed status then the register content
// R16 - a write not taken is completed when the next frame arrives
// R17 - master holds select low over 5.5 us, lead time at least 550 ns
// R18 - master follows writes with one read, such as the id read 0x2580
// R19 - some registers also report device flags under the flag read
`ifndef SBCFD_DEFINES_SVH
`define SBCFD_DEFINES_SVH

`define SBCFD_FRAME_BITS 5'h10
`define SBCFD_RESP_AT 5'h08
`define SBCFD_CNT_MAX 5'h11
`define SBCFD_REG_RST 8'h00
`define SBCFD_BYTE_ZERO 8'h00
// pins at rest {sclk, select, mosi}: clock low, select high
`define SBCFD_PIN_IDLE 3'h2
`define SBCFD_FLAG_MASK 32'h000f0000
`define SBCFD_CLK_NS 40
`define SBCFD_CSLOW_NS 5500
`define SBCFD_LEAD_NS 550
// least times round up to whole cycles
`define SBCFD_CSLOW_CYC ((`SBCFD_CSLOW_NS + `SBCFD_CLK_NS - 1) / `SBCFD_CLK_NS)
`define SBCFD_LEAD_CYC ((`SBCFD_LEAD_NS + `SBCFD_CLK_NS - 1) / `SBCFD_CLK_NS)

`endif

// ===== include/sbcfd_pkg.sv
// types shared by the sbc spi frame decoder
`default_nettype none
package sbcfd_pkg;
    typedef enum logic [1:0] {
        SBCFD_OP_READ  = 2'h0,
        SBCFD_OP_WRITE = 2'h1,
        SBCFD_OP_RSVD  = 2'h2,
        SBCFD_OP_FLAGS = 2'h3
    } sbcfd_op_e;

    typedef enum logic [2:0] {
        SBCFD_ST_IDLE  = 3'h1,
        SBCFD_ST_SHIFT = 3'h2,
        SBCFD_ST_END   = 3'h4
    } sbcfd_state_e;

    // one mosi frame, msb first
    typedef struct packed {
        sbcfd_op_e op;
        logic [4:0] reg_addr_field;
        logic pn;
        logic [7:0] write_payload_bits;
    } sbcfd_frame_s;
endpackage : sbcfd_pkg
`default_nettype wire

// ===== hw/sbcfd_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module sbcfd_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // meta stage feeds only the second stage; reset to idle pin levels
    // so no false edge appears once reset lets go
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : sbcfd_sync
`default_nettype wire

// ===== hw/sbcfd_top.sv
// spi slave frame decoder with register file
`default_nettype none
`include "sbcfd_defines.svh"
module sbcfd_top #(
    parameter logic [31:0] FLAG_MASK = `SBCFD_FLAG_MASK
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    input wire logic [7:0] fixed_status_byte_i,
    input wire logic [7:0] ext_status_i,
    input wire logic [31:0][7:0] dev_flags_i,
    input wire logic parity_en_i,
    input wire logic late_commit_i,
    output logic [31:0][7:0] ctrl_regs_o,
    output logic wr_strobe_o,
    output logic [4:0] wr_addr_o,
    output logic flag_clr_o,
    output logic [4:0] flag_clr_addr_o,
    output logic frame_err_o,
    output logic parity_err_o,
    output logic timing_err_o
);
    logic [2:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;

    // pins are asynchronous to sys_clk_i
    sbcfd_sync #(.W(3), .RST_VAL(`SBCFD_PIN_IDLE)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
        .q_o(pins_s)
    );
    assign sclk_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign mosi_s = pins_s[0];

    sbcfd_pkg::sbcfd_state_e state_q, state_d;
    logic sclk_prev_q, sclk_prev_d;
    logic cs_prev_q, cs_prev_d;
    logic [15:0] rx_q, rx_d;
    logic [4:0] cnt_q, cnt_d;
    logic [6:0] tx_q, tx_d;
    logic miso_q, miso_d;
    logic oe_n_q, oe_n_d;
    logic [7:0] low_cnt_q, low_cnt_d;
    logic lead_bad_q, lead_bad_d;
    logic pend_q, pend_d;
    logic [4:0] pend_addr_q, pend_addr_d;
    logic [7:0] pend_data_q, pend_data_d;
    logic [31:0][7:0] regs_q, regs_d;
    logic wr_q, wr_d;
    logic [4:0] wr_addr_q, wr_addr_d;
    logic fclr_q, fclr_d;
    logic [4:0] fclr_addr_q, fclr_addr_d;
    logic ferr_q, ferr_d;
    logic perr_q, perr_d;
    logic terr_q, terr_d;

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    sbcfd_pkg::sbcfd_frame_s frame;
    sbcfd_pkg::sbcfd_frame_s head;
    logic [7:0] resp;
    logic full_frame;
    logic parity_ok;
    logic wr_en;
    logic [4:0] wr_a;
    logic [7:0] wr_dat;

    // edges seen on the synchronised copies only
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;
    assign cs_fall = cs_prev_q & ~cs_n_s;
    assign cs_rise = ~cs_prev_q & cs_n_s;

    // whole frame at the end, header byte once eight bits are in
    assign frame = sbcfd_pkg::sbcfd_frame_s'(rx_q); // R2 R3 R5
    assign head = sbcfd_pkg::sbcfd_frame_s'({rx_q[7:0], `SBCFD_BYTE_ZERO});
    assign full_frame = (cnt_q == `SBCFD_FRAME_BITS); // R1
    // bit 8 must equal the xor of the other fifteen when checking is on
    assign parity_ok = ~parity_en_i |
        (frame.pn == ^{rx_q[15:9], rx_q[7:0]}); // R10

    // low byte of miso chosen from the command just received
    always_comb begin
        resp = ext_status_i; // R14
        case (head.op)
            sbcfd_pkg::SBCFD_OP_READ: begin
                resp = regs_q[head.reg_addr_field]; // R9 R13 R15
            end
            sbcfd_pkg::SBCFD_OP_WRITE: begin
                resp = ext_status_i; // R14
            end
            sbcfd_pkg::SBCFD_OP_FLAGS: begin
                if (FLAG_MASK[head.reg_addr_field]) begin
                    resp = dev_flags_i[head.reg_addr_field]; // R12 R19
                end else begin
                    resp = `SBCFD_BYTE_ZERO;
                end
            end
            default: begin
                resp = ext_status_i; // R11
            end
        endcase
    end

    // frame sequencing, shifting and commit decisions
    always_comb begin
        state_d = state_q;
        sclk_prev_d = sclk_s;
        cs_prev_d = cs_n_s;
        rx_d = rx_q;
        cnt_d = cnt_q;
        tx_d = tx_q;
        miso_d = miso_q;
        oe_n_d = oe_n_q;
        low_cnt_d = low_cnt_q;
        lead_bad_d = lead_bad_q;
        pend_d = pend_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        wr_d = 1'b0;
        wr_addr_d = wr_addr_q;
        fclr_d = 1'b0;
        fclr_addr_d = fclr_addr_q;
        ferr_d = ferr_q;
        perr_d = perr_q;
        terr_d = terr_q;
        wr_en = 1'b0;
        wr_a = pend_addr_q;
        wr_dat = pend_data_q;
        case (state_q)
            sbcfd_pkg::SBCFD_ST_IDLE: begin
                miso_d = 1'b0; // R8
                oe_n_d = 1'b1;
                if (cs_fall) begin
                    state_d = sbcfd_pkg::SBCFD_ST_SHIFT;
                    cnt_d = 5'h00;
                    low_cnt_d = 8'h00;
                    lead_bad_d = 1'b0;
                    oe_n_d = 1'b0;
                    // status msb must be on the wire before first rise
                    miso_d = fixed_status_byte_i[7]; // R6
                    tx_d = fixed_status_byte_i[6:0]; // R6
                    if (pend_q) begin
                        // held write finishes as the next frame begins
                        wr_en = 1'b1; // R16
                        pend_d = 1'b0;
                    end
                end
            end
            sbcfd_pkg::SBCFD_ST_SHIFT: begin
                if (low_cnt_q != 8'(`SBCFD_CSLOW_CYC)) begin
                    low_cnt_d = low_cnt_q + 8'h01;
                end
                if (sclk_rise && cnt_q != `SBCFD_CNT_MAX) begin
                    rx_d = {rx_q[14:0], mosi_s};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'h00 &&
                        low_cnt_q < 8'(`SBCFD_LEAD_CYC)) begin
                        lead_bad_d = 1'b1; // R17
                    end
                end
                if (sclk_fall && cnt_q == `SBCFD_RESP_AT) begin
                    miso_d = resp[7]; // R7
                    tx_d = resp[6:0];
                end else if (sclk_fall) begin
                    // only our own bytes ever reach miso
                    miso_d = tx_q[6]; // R8
                    tx_d = {tx_q[5:0], 1'b0};
                end
                if (cs_rise) begin
                    state_d = sbcfd_pkg::SBCFD_ST_END;
                    oe_n_d = 1'b1;
                    miso_d = 1'b0;
                end
            end
            sbcfd_pkg::SBCFD_ST_END: begin
                state_d = sbcfd_pkg::SBCFD_ST_IDLE;
                ferr_d = ~full_frame; // R1
                perr_d = full_frame &&
                    frame.op == sbcfd_pkg::SBCFD_OP_WRITE && !parity_ok;
                terr_d = lead_bad_q ||
                    low_cnt_q < 8'(`SBCFD_CSLOW_CYC); // R17
                if (full_frame && parity_ok &&
                    frame.op == sbcfd_pkg::SBCFD_OP_WRITE) begin
                    if (late_commit_i) begin
                        // any older held write was already committed as this frame began
                        pend_d = 1'b1; // R16
                        pend_addr_d = frame.reg_addr_field;
                        pend_data_d = frame.write_payload_bits;
                    end else begin
                        wr_en = 1'b1; // R10
                        wr_a = frame.reg_addr_field; // R3
                        wr_dat = frame.write_payload_bits; // R5
                    end
                end
                if (full_frame && frame.op == sbcfd_pkg::SBCFD_OP_FLAGS &&
                    FLAG_MASK[frame.reg_addr_field]) begin
                    fclr_d = 1'b1; // R12 R19
                    fclr_addr_d = frame.reg_addr_field;
                end
            end
            default: begin
                state_d = sbcfd_pkg::SBCFD_ST_IDLE;
                oe_n_d = 1'b1;
                miso_d = 1'b0;
            end
        endcase
        regs_d = regs_q;
        if (wr_en) begin
            regs_d[wr_a] = wr_dat; // R13
            wr_d = 1'b1;
            wr_addr_d = wr_a;
        end
    end

    // state registers only
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= sbcfd_pkg::SBCFD_ST_IDLE;
            sclk_prev_q <= 1'b0; // matches the idle low clock pin
            cs_prev_q <= 1'b1;
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
            tx_q <= 7'h00;
            miso_q <= 1'b0;
            oe_n_q <= 1'b1;
            low_cnt_q <= 8'h00;
            lead_bad_q <= 1'b0;
            pend_q <= 1'b0;
            pend_addr_q <= 5'h00;
            pend_data_q <= 8'h00;
            regs_q <= {32{`SBCFD_REG_RST}};
            wr_q <= 1'b0;
            wr_addr_q <= 5'h00;
            fclr_q <= 1'b0;
            fclr_addr_q <= 5'h00;
            ferr_q <= 1'b0;
            perr_q <= 1'b0;
            terr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sclk_prev_q <= sclk_prev_d;
            cs_prev_q <= cs_prev_d;
            rx_q <= rx_d;
            cnt_q <= cnt_d;
            tx_q <= tx_d;
            miso_q <= miso_d;
            oe_n_q <= oe_n_d;
            low_cnt_q <= low_cnt_d;
            lead_bad_q <= lead_bad_d;
            pend_q <= pend_d;
            pend_addr_q <= pend_addr_d;
            pend_data_q <= pend_data_d;
            regs_q <= regs_d;
            wr_q <= wr_d;
            wr_addr_q <= wr_addr_d;
            fclr_q <= fclr_d;
            fclr_addr_q <= fclr_addr_d;
            ferr_q <= ferr_d;
            perr_q <= perr_d;
            terr_q <= terr_d;
        end
    end

    // every output straight from a flop
    assign spi_miso_o = miso_q;
    assign spi_miso_oe_n_o = oe_n_q;
    assign ctrl_regs_o = regs_q;
    assign wr_strobe_o = wr_q;
    assign wr_addr_o = wr_addr_q;
    assign flag_clr_o = fclr_q;
    assign flag_clr_addr_o = fclr_addr_q;
    assign frame_err_o = ferr_q;
    assign parity_err_o = perr_q;
    assign timing_err_o = terr_q;

    // short frames never write
    short_frame_a: assert property (@(posedge sys_clk_i) // R1
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_END && !full_frame)
        |=> !wr_strobe_o ##1 frame_err_o)
        else $error("short frame caused a write");

    // reserved code has no side effect
    rsvd_op_a: assert property (@(posedge sys_clk_i) // R11
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_END &&
         frame.op == sbcfd_pkg::SBCFD_OP_RSVD)
        |=> !wr_strobe_o && !flag_clr_o)
        else $error("reserved code acted");

    // status msb and drive at frame start
    status_first_a: assert property (@(posedge sys_clk_i) // R6
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_IDLE && cs_fall)
        |=> !spi_miso_oe_n_o && spi_miso_o == $past(fixed_status_byte_i[7]))
        else $error("status msb not driven at select");

    // read back byte follows the header
    read_back_a: assert property (@(posedge sys_clk_i) // R15
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_SHIFT && sclk_fall &&
         cnt_q == `SBCFD_RESP_AT && head.op == sbcfd_pkg::SBCFD_OP_READ)
        |=> spi_miso_o == $past(regs_q[head.reg_addr_field][7]))
        else $error("read back bit wrong");

    // direct write lands one cycle later
    write_commit_a: assert property (@(posedge sys_clk_i) // R10
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_END && full_frame && parity_ok &&
         frame.op == sbcfd_pkg::SBCFD_OP_WRITE && !late_commit_i)
        |=> wr_strobe_o && wr_addr_o == $past(frame.reg_addr_field) &&
        ctrl_regs_o[wr_addr_o] == $past(frame.write_payload_bits))
        else $error("write not committed");

    // held write completes at the next select
    late_write_a: assert property (@(posedge sys_clk_i) // R16
        disable iff (rst_i)
        (pend_q && state_q == sbcfd_pkg::SBCFD_ST_IDLE && cs_fall)
        |=> wr_strobe_o && wr_addr_o == $past(pend_addr_q) && !pend_q)
        else $error("held write lost");

    // flag read pulses the clear for flagged addresses
    flag_clear_a: assert property (@(posedge sys_clk_i) // R12
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_END && full_frame &&
         frame.op == sbcfd_pkg::SBCFD_OP_FLAGS)
        |=> flag_clr_o == $past(FLAG_MASK[frame.reg_addr_field]) ##1
        !flag_clr_o)
        else $error("flag clear wrong");

    // miso quiet and released between frames
    idle_quiet_a: assert property (@(posedge sys_clk_i) // R8
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_IDLE && !cs_fall) [*2]
        |-> !spi_miso_o && spi_miso_oe_n_o)
        else $error("miso active outside frame");

    // short select low reported
    select_time_a: assert property (@(posedge sys_clk_i) // R17
        disable iff (rst_i)
        (state_q == sbcfd_pkg::SBCFD_ST_END &&
         low_cnt_q < 8'(`SBCFD_CSLOW_CYC)) |=> timing_err_o)
        else $error("short select not flagged");
endmodule : sbcfd_top
`default_nettype wire

// ===== testbench/sbcfd_master.sv
// spi master model standing in for the microcontroller
`default_nettype none
module sbcfd_master (
    input wire logic sys_clk_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // sclk half period in clocks; the decoder needs at least 4
    localparam int HALF = 5;
    // lead in clocks, above the 14-cycle minimum
    localparam int LEAD = 16;

    // sclk idles low between frames, never free running
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // one frame of nbits, msb first, mode 0; miso taken at each rise
    task automatic frame(input logic [15:0] tx, input int nbits,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        repeat (LEAD - HALF) @(posedge sys_clk_i);
        for (int i = 0; i < nbits; i++) begin
            mosi_o <= tx[15 - i];
            repeat (HALF) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            rx = {rx[14:0], miso_i};
            repeat (HALF) @(posedge sys_clk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        // released line must not keep showing the last bit
        mosi_o <= ~mosi_o;
        // select stays high well over the 2-clock minimum
        repeat (4) @(posedge sys_clk_i);
    endtask : frame
endmodule : sbcfd_master
`default_nettype wire

// ===== testbench/tb_sbcfd_top.sv
// self-checking bench of the spi frame decoder
`default_nettype none
module tb_sbcfd_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] STAT = 8'hc3;
    localparam logic [7:0] EXT = 8'h3c;
    logic sys_clk_i, rst_i, sclk, cs_n, mosi, miso, oe_n;
    logic [7:0] fixed_status, ext_status;
    logic [31:0][7:0] dev_flags, ctrl_regs;
    logic parity_en, late_commit, wr_strobe, flag_clr;
    logic [4:0] wr_addr, flag_clr_addr;
    logic frame_err, parity_err, timing_err;
    int n_errors = 0;
    int total_checks = 0;
    int n_wr = 0;
    int n_clr = 0;

    sbcfd_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n),
        .fixed_status_byte_i(fixed_status), .ext_status_i(ext_status),
        .dev_flags_i(dev_flags), .parity_en_i(parity_en),
        .late_commit_i(late_commit), .ctrl_regs_o(ctrl_regs),
        .wr_strobe_o(wr_strobe), .wr_addr_o(wr_addr),
        .flag_clr_o(flag_clr), .flag_clr_addr_o(flag_clr_addr),
        .frame_err_o(frame_err), .parity_err_o(parity_err),
        .timing_err_o(timing_err));
    sbcfd_master u_master (.sys_clk_i(sys_clk_i), .sclk_o(sclk),
        .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

    // count one-cycle pulses so tests need not hit their exact edge
    always @(posedge sys_clk_i) begin
        if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
        if (flag_clr === 1'b1) n_clr <= n_clr + 1;
    end

    task automatic check_val(input logic [15:0] got,
                             input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : check_val

    function automatic logic par(input logic [15:0] v);
        return ^{v[15:9], v[7:0]};
    endfunction : par

    // frame plus room for the end-of-frame pulses to land
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
        u_master.frame(tx, nbits, rx);
        repeat (8) @(posedge sys_clk_i);
    endtask : xfer

    task automatic test_write_read();
        logic [15:0] rx;
        int w0;
        w0 = n_wr;
        xfer({2'h0, 5'h07, 1'b1, 8'h00}, 16, rx);
        check_val(rx, {STAT, 8'h00}, "reset read");
        check_val(16'(timing_err), 16'h0000, "select time ok");
        check_val(16'(oe_n), 16'h0001, "miso released");
        // writes and reads back to back; read data ff shows no echo
        for (int a = 0; a < 32; a += 9) begin
            xfer({2'h1, a[4:0], 1'b0, 8'(a * 7 + 1)}, 16, rx);
            check_val(rx, {STAT, EXT}, "write status");
            check_val(16'(wr_addr), 16'(a[4:0]), "wr addr");
            check_val(16'(ctrl_regs[a]), 16'(a * 7 + 1), "reg");
            xfer({2'h0, a[4:0], 1'b1, 8'hff}, 16, rx);
            check_val(rx, {STAT, 8'(a * 7 + 1)}, "read back");
        end
        check_val(16'(n_wr - w0), 16'h0004, "write count");
        $display("test write_read done");
    endtask : test_write_read

    task automatic test_flags();
        logic [15:0] rx;
        int c0;
        logic hit;
        logic [7:0] fexp;
        // edges of the flagged range, 0x10 to 0x13
        for (int a = 15; a <= 20; a++) begin
            c0 = n_clr;
            hit = (a >= 16) && (a <= 19);
            xfer({2'h3, a[4:0], 1'b1, 8'h00}, 16, rx);
            fexp = hit ? dev_flags[a] : 8'h00;
            check_val(rx, {STAT, fexp}, "flags");
            check_val(16'(n_clr - c0), 16'(hit), "flag clear");
            if (hit) check_val(16'(flag_clr_addr), 16'(a), "clr addr");
        end
        $display("test flags done");
    endtask : test_flags

    task automatic test_reserved();
        logic [15:0] rx;
        int w0;
        int c0;
        w0 = n_wr;
        c0 = n_clr;
        xfer({2'h2, 5'h10, 1'b1, 8'h77}, 16, rx);
        check_val(rx, {STAT, EXT}, "reserved status");
        check_val(16'(n_wr - w0), 16'h0000, "no write");
        check_val(16'(n_clr - c0), 16'h0000, "no clear");
        check_val(16'(ctrl_regs[16]), 16'h0000, "reg kept");
        $display("test reserved done");
    endtask : test_reserved

    task automatic test_parity();
        logic [15:0] rx;
        logic [15:0] v;
        int w0;
        v = {2'h1, 5'h04, 1'b0, 8'h5a};
        v[8] = par(v);
        parity_en <= 1'b1;
        w0 = n_wr;
        xfer(v ^ 16'h0100, 16, rx);
        check_val(16'(parity_err), 16'h0001, "parity refused");
        check_val(16'(n_wr - w0), 16'h0000, "no write");
        xfer(v, 16, rx);
        check_val(16'(parity_err), 16'h0000, "parity ok");
        check_val(16'(ctrl_regs[4]), 16'h005a, "reg");
        parity_en <= 1'b0;
        $display("test parity done");
    endtask : test_parity

    task automatic test_short();
        logic [15:0] rx;
        int w0;
        w0 = n_wr;
        xfer({2'h1, 5'h02, 1'b0, 8'h99}, 12, rx);
        check_val(16'(frame_err), 16'h0001, "short frame");
        // twelve bits leave select low for 136 clocks, under 5.5 us
        check_val(16'(timing_err), 16'h0001, "short select");
        check_val(16'(n_wr - w0), 16'h0000, "no write");
        xfer({2'h0, 5'h02, 1'b1, 8'h00}, 16, rx);
        check_val(16'(frame_err), 16'h0000, "full frame");
        check_val(16'(timing_err), 16'h0000, "long select");
        check_val(rx, {STAT, 8'h00}, "reg kept");
        $display("test short done");
    endtask : test_short

    task automatic test_late();
        logic [15:0] rx;
        int w0;
        late_commit <= 1'b1;
        w0 = n_wr;
        xfer(16'h60c0, 16, rx);
        check_val(16'(n_wr - w0), 16'h0000, "held");
        check_val(16'(ctrl_regs[16]), 16'h0000, "not yet");
        xfer(16'h2580, 16, rx);
        check_val(rx, {STAT, 8'h7f}, "id read");
        check_val(16'(n_wr - w0), 16'h0001, "committed");
        check_val(16'(ctrl_regs[16]), 16'h00c0, "late reg");
        check_val(16'(wr_addr), 16'h0010, "late addr");
        late_commit <= 1'b0;
        $display("test late done");
    endtask : test_late

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (total_checks > 0 && n_errors == 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // status bytes differ so a swapped byte cannot pass
    initial begin
        rst_i = 1'b1;
        fixed_status = STAT;
        ext_status = EXT;
        parity_en = 1'b0;
        late_commit = 1'b0;
        for (int i = 0; i < 32; i++) dev_flags[i] = 8'(i) ^ 8'ha5;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        test_write_read();
        test_flags();
        test_reserved();
        test_parity();
        test_short();
        test_late();
        end_of_test();
    end

    // about 22 frames of under 200 clocks; allow several times that
    initial begin
        #800000;
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_sbcfd_top
`default_nettype wire
